// file: hdl/ics_defines.vh
// constants for the common-command and status unit
`ifndef ICS_DEFINES_VH
`define ICS_DEFINES_VH
// command codes on CMD_CODE
`define ICS_CMD_CLS      4'h0
`define ICS_CMD_ESE      4'h1
`define ICS_CMD_ESR_Q    4'h2
`define ICS_CMD_OPC      4'h3
`define ICS_CMD_OPC_Q    4'h4
`define ICS_CMD_OPT_Q    4'h5
`define ICS_CMD_PSC      4'h6
`define ICS_CMD_RCL      4'h7
`define ICS_CMD_RST      4'h8
`define ICS_CMD_SAV      4'h9
`define ICS_CMD_SRE      4'ha
`define ICS_CMD_STB_Q    4'hb
`define ICS_CMD_TRG      4'hc
`define ICS_CMD_TST_Q    4'hd
`define ICS_CMD_WAI      4'he
`define ICS_CMD_OTHER    4'hf
// standard event bits
`define ICS_EV_OPC       0
`define ICS_EV_QUE       2
`define ICS_EV_DDE       3
`define ICS_EV_EXE       4
`define ICS_EV_CME       5
`define ICS_EV_PON       7
`define ICS_EV_USED      8'hbd
// status byte bits
`define ICS_SB_QUES      3
`define ICS_SB_MAV       4
`define ICS_SB_ESB       5
`define ICS_SB_RQS       6
`define ICS_SB_OPER      7
`define ICS_SB_SUMMASK   8'hbf
// answers
`define ICS_ASCII_ONE    8'h31
`define ICS_PASS         8'h00
`define ICS_FAIL         8'h01
// nonvolatile slots: 0..3 states, 4 the enable registers
`define ICS_NV_ESE_SLOT  3'h4
`define ICS_STATE_SLOTS  4
// factory defaults
`define ICS_RST_POINTS   16'h0800
`define ICS_RST_TINT_NS  15600
`define ICS_CLK_NS       50
`define ICS_TRIG_BUS     2'h1
`define ICS_TRIG_INT     2'h0
`endif

// file: hdl/ics_nvmem.v
// small nonvolatile store for saved states and enable registers
`timescale 1ns/10ps
module ics_nvmem #(
  parameter AW = 3,
  parameter DW = 32
) (
  // clock
  input  wire          CLK,
  // write port
  input  wire          WR_EN,
  input  wire [AW-1:0] WR_ADDR,
  input  wire [DW-1:0] WR_DATA,
  // read port
  input  wire [AW-1:0] RD_ADDR,
  output reg  [DW-1:0] RD_DATA
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  // no reset: contents model retention across power cycles
  always @(posedge CLK) begin
    if (WR_EN) begin
      mem[WR_ADDR] <= WR_DATA;
    end
    RD_DATA <= mem[RD_ADDR];
  end
endmodule

// file: hdl/ics_unit.v
// common-command interpreter and status reporting unit
`timescale 1ns/10ps
`include "ics_defines.vh"
module ics_unit #(
  parameter [7:0]  OPTION_CODE = 8'h00,
  parameter        TINT_NS     = `ICS_RST_TINT_NS,
  parameter        CLK_NS      = `ICS_CLK_NS
) (
  // clock and reset
  input  wire        CLK,
  input  wire        RST_N,
  // command port from the parser
  input  wire        CMD_VALID,
  output wire        CMD_READY,
  input  wire [3:0]  CMD_CODE,
  input  wire [7:0]  CMD_ARG,
  input  wire        CMD_AFTER_TERM,
  input  wire        CMD_OVERLAP,
  // instrument side
  input  wire        OVL_BUSY,
  input  wire        TRIG_BUSY,
  input  wire        OPER_SUMMARY,
  input  wire        QUES_SUMMARY,
  input  wire        EVT_CME,
  input  wire        EVT_EXE,
  input  wire        EVT_DDE,
  input  wire        EVT_QUE,
  input  wire        POWERON_RCL0,
  input  wire        DEVICE_CLEAR,
  input  wire        SERIAL_POLL,
  input  wire        SELFTEST_FAIL,
  input  wire [7:0]  SELFTEST_CODE,
  input  wire        OUTQ_EMPTY,
  input  wire [31:0] STATE_IN,
  // answers and controls
  output reg         RESP_VALID,
  output reg  [7:0]  RESP_DATA,
  output reg         ERRQ_PUSH,
  output reg  [7:0]  ERRQ_CODE,
  output reg         ERRQ_CLEAR,
  output reg         OUTQ_CLEAR,
  output reg         EVREG_CLEAR,
  output reg         BUS_TRIGGER,
  output reg         ABORT,
  output reg         CAL_OFF,
  output reg         STATE_LOAD,
  output reg  [31:0] STATE_OUT,
  output reg  [15:0] SWEEP_POINTS,
  output reg  [15:0] SAMPLE_TICKS,
  output reg         OUTPUT_ON,
  output reg  [1:0]  TRIG_SOURCE,
  output wire        SRQ,
  output wire [7:0]  STATUS_BYTE,
  output wire [7:0]  POLL_BYTE,
  output reg  [7:0]  SRE_VALUE,
  output reg  [7:0]  ESE_VALUE,
  output reg         PSC_VALUE
);
  // ==========================================================
  // state machine
  localparam ST_BOOT  = 3'h0;
  localparam ST_BOOT2 = 3'h1;
  localparam ST_BOOT3 = 3'h2;
  localparam ST_RUN   = 3'h3;
  localparam ST_WAIT  = 3'h4;
  localparam ST_OPCQ  = 3'h5;
  localparam ST_RCL   = 3'h6;
  localparam ST_RCL2  = 3'h7;

  // round the interval up to whole clock ticks, then keep the low 16 bits on purpose
  localparam integer TINT_FULL  = (TINT_NS + CLK_NS - 1) / CLK_NS;
  localparam [15:0]  TINT_TICKS = TINT_FULL[15:0];

  reg  [2:0] st_q;
  reg  [7:0] esr_q;
  reg        opc_arm_q;
  reg        rqs_q;
  reg        mss_q;
  reg        psc_q;
  reg        seq_busy_q;
  reg        boot_rcl_q;
  reg        nv_we;
  reg  [2:0] nv_wa;
  reg [31:0] nv_wd;
  reg  [2:0] nv_ra_q;
  wire [31:0] nv_rd;
  wire       pending;
  wire       accept;
  wire [7:0] ev_in;
  wire       esb;
  wire       mav;
  wire       mss;
  wire [7:0] sb_raw;

  // ==========================================================
  // nonvolatile store
  ics_nvmem #(.AW(3), .DW(32)) u_nv (
    .CLK     (CLK),
    .WR_EN   (nv_we),
    .WR_ADDR (nv_wa),
    .WR_DATA (nv_wd),
    .RD_ADDR (nv_ra_q),
    .RD_DATA (nv_rd)
  );

  // ==========================================================
  // status summary
  assign pending = OVL_BUSY | TRIG_BUSY | seq_busy_q;
  assign esb = |(esr_q & ESE_VALUE & `ICS_EV_USED);
  assign mav = ~OUTQ_EMPTY;
  assign sb_raw = {OPER_SUMMARY, 1'b0, esb, mav, QUES_SUMMARY, 3'h0};
  assign mss = |(sb_raw & SRE_VALUE & `ICS_SB_SUMMASK);
  assign STATUS_BYTE = sb_raw | {1'b0, mss, 6'h00};
  assign POLL_BYTE = sb_raw | {1'b0, rqs_q, 6'h00};
  assign SRQ = rqs_q & (|SRE_VALUE);
  // only run accepts; wait and query states stall the parser
  assign accept = CMD_VALID & CMD_READY;
  assign CMD_READY = (st_q == ST_RUN) & ~seq_busy_q;
  assign ev_in = {1'b0, 1'b0, EVT_CME, EVT_EXE, EVT_DDE, EVT_QUE, 2'h0};

  // ==========================================================
  // main process
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q         <= ST_BOOT;
      esr_q        <= 8'h00;
      opc_arm_q    <= 1'b0;
      rqs_q        <= 1'b0;
      mss_q        <= 1'b0;
      psc_q        <= 1'b1;
      seq_busy_q   <= 1'b0;
      boot_rcl_q   <= 1'b0;
      nv_we        <= 1'b0;
      nv_wa        <= 3'h0;
      nv_wd        <= 32'h0000_0000;
      nv_ra_q      <= 3'h0;
      RESP_VALID   <= 1'b0;
      RESP_DATA    <= 8'h00;
      ERRQ_PUSH    <= 1'b0;
      ERRQ_CODE    <= 8'h00;
      ERRQ_CLEAR   <= 1'b0;
      OUTQ_CLEAR   <= 1'b0;
      EVREG_CLEAR  <= 1'b0;
      BUS_TRIGGER  <= 1'b0;
      ABORT        <= 1'b0;
      CAL_OFF      <= 1'b0;
      STATE_LOAD   <= 1'b0;
      STATE_OUT    <= 32'h0000_0000;
      SWEEP_POINTS <= `ICS_RST_POINTS;
      SAMPLE_TICKS <= 16'h0000;
      OUTPUT_ON    <= 1'b0;
      TRIG_SOURCE  <= `ICS_TRIG_BUS;
      SRE_VALUE    <= 8'h00;
      ESE_VALUE    <= 8'h00;
      PSC_VALUE    <= 1'b1;
    end else begin
      nv_we       <= 1'b0;
      RESP_VALID  <= 1'b0;
      ERRQ_PUSH   <= 1'b0;
      ERRQ_CLEAR  <= 1'b0;
      OUTQ_CLEAR  <= 1'b0;
      EVREG_CLEAR <= 1'b0;
      BUS_TRIGGER <= 1'b0;
      ABORT       <= 1'b0;
      CAL_OFF     <= 1'b0;
      STATE_LOAD  <= 1'b0;
      seq_busy_q  <= 1'b0;
      PSC_VALUE   <= psc_q;
      mss_q       <= mss;
      // request goes up only on a new rise of the summary, so a poll is not
      // followed by a fresh request while the same reason still stands
      if (mss & ~mss_q) begin
        rqs_q <= 1'b1;
      end else if (SERIAL_POLL | ~mss) begin
        rqs_q <= 1'b0;
      end
      // event capture; the clears below win by ordering and fold ev_in back in themselves
      esr_q <= esr_q | ev_in;
      if (opc_arm_q & ~pending) begin
        esr_q[`ICS_EV_OPC] <= 1'b1;
        opc_arm_q <= 1'b0;
      end
      case (st_q)
        ST_BOOT: begin
          // power-on: enables come from storage, or are zeroed if the stored clear flag is set, then optional recall
          esr_q[`ICS_EV_PON] <= 1'b1;
          boot_rcl_q <= POWERON_RCL0;
          nv_ra_q <= `ICS_NV_ESE_SLOT;
          st_q <= ST_BOOT2;
        end
        ST_BOOT2: begin
          st_q <= ST_BOOT3;
        end
        ST_BOOT3: begin
          psc_q <= nv_rd[16];
          if (nv_rd[16]) begin
            SRE_VALUE <= 8'h00;
            ESE_VALUE <= 8'h00;
          end else begin
            SRE_VALUE <= nv_rd[15:8];
            ESE_VALUE <= nv_rd[7:0];
          end
          if (boot_rcl_q) begin
            nv_ra_q <= 3'h0;
            st_q <= ST_RCL;
          end else begin
            st_q <= ST_RUN;
          end
        end
        ST_RCL: begin
          st_q <= ST_RCL2;
        end
        ST_RCL2: begin
          STATE_OUT  <= nv_rd;
          STATE_LOAD <= 1'b1;
          ABORT      <= 1'b1;
          CAL_OFF    <= 1'b1;
          st_q <= ST_RUN;
        end
        ST_WAIT: begin
          if (DEVICE_CLEAR | ~pending) begin
            st_q <= ST_RUN;
          end
        end
        ST_OPCQ: begin
          if (~pending) begin
            RESP_VALID <= 1'b1;
            RESP_DATA  <= `ICS_ASCII_ONE;
            st_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (accept) begin
            // sequential commands hold the next one off one cycle
            seq_busy_q <= ~CMD_OVERLAP;
            case (CMD_CODE)
              `ICS_CMD_CLS: begin
                esr_q <= ev_in;
                opc_arm_q <= 1'b0;
                EVREG_CLEAR <= 1'b1;
                ERRQ_CLEAR <= 1'b1;
                OUTQ_CLEAR <= CMD_AFTER_TERM;
              end
              `ICS_CMD_ESE: begin
                ESE_VALUE <= CMD_ARG;
                nv_we <= ~psc_q;
                nv_wa <= `ICS_NV_ESE_SLOT;
                nv_wd <= {15'h0000, psc_q, SRE_VALUE, CMD_ARG};
              end
              `ICS_CMD_SRE: begin
                SRE_VALUE <= CMD_ARG;
                nv_we <= ~psc_q;
                nv_wa <= `ICS_NV_ESE_SLOT;
                nv_wd <= {15'h0000, psc_q, CMD_ARG, ESE_VALUE};
              end
              `ICS_CMD_PSC: begin
                psc_q <= CMD_ARG[0];
                nv_we <= 1'b1;
                nv_wa <= `ICS_NV_ESE_SLOT;
                nv_wd <= {15'h0000, CMD_ARG[0], SRE_VALUE, ESE_VALUE};
              end
              `ICS_CMD_ESR_Q: begin
                RESP_VALID <= 1'b1;
                RESP_DATA  <= esr_q;
                // a completion landing on the read edge is kept for the next read
                esr_q <= ev_in | {7'h00, opc_arm_q & ~pending};
              end
              `ICS_CMD_STB_Q: begin
                RESP_VALID <= 1'b1;
                RESP_DATA  <= STATUS_BYTE;
              end
              `ICS_CMD_OPC: begin
                opc_arm_q <= 1'b1;
              end
              `ICS_CMD_OPC_Q: begin
                st_q <= ST_OPCQ;
              end
              `ICS_CMD_WAI: begin
                st_q <= ST_WAIT;
              end
              `ICS_CMD_OPT_Q: begin
                RESP_VALID <= 1'b1;
                RESP_DATA  <= OPTION_CODE;
              end
              `ICS_CMD_TST_Q: begin
                RESP_VALID <= 1'b1;
                RESP_DATA  <= SELFTEST_FAIL ? `ICS_FAIL : `ICS_PASS;
                ERRQ_PUSH  <= SELFTEST_FAIL;
                ERRQ_CODE  <= SELFTEST_CODE;
              end
              `ICS_CMD_SAV: begin
                nv_we <= 1'b1;
                nv_wa <= {1'b0, CMD_ARG[1:0]};
                nv_wd <= STATE_IN;
              end
              `ICS_CMD_RCL: begin
                nv_ra_q <= {1'b0, CMD_ARG[1:0]};
                st_q <= ST_RCL;
              end
              `ICS_CMD_RST: begin
                SWEEP_POINTS <= `ICS_RST_POINTS;
                SAMPLE_TICKS <= TINT_TICKS;
                OUTPUT_ON    <= 1'b0;
                CAL_OFF      <= 1'b1;
                TRIG_SOURCE  <= `ICS_TRIG_BUS;
                ABORT        <= 1'b1;
              end
              `ICS_CMD_TRG: begin
                BUS_TRIGGER <= (TRIG_SOURCE == `ICS_TRIG_BUS);
              end
              default: begin
                seq_busy_q <= 1'b0;
              end
            endcase
          end
        end
        default: begin
          st_q <= ST_RUN;
        end
      endcase
    end
  end
endmodule

// file: tb/ics_unit_chk.sv
// concurrent checks on the ports of the common-command and status unit
`timescale 1ns/10ps
`include "ics_defines.vh"
module ics_unit_chk (
  // clock and reset
  input wire       CLK,
  input wire       RST_N,
  // command port
  input wire       CMD_VALID,
  input wire       CMD_READY,
  input wire [3:0] CMD_CODE,
  // instrument side
  input wire       TRIG_BUSY,
  input wire       OUTQ_EMPTY,
  input wire       SERIAL_POLL,
  // answers
  input wire       SRQ,
  input wire [7:0] STATUS_BYTE,
  input wire [7:0] POLL_BYTE,
  input wire [7:0] SRE_VALUE,
  input wire       RESP_VALID,
  input wire       STATE_LOAD,
  input wire       ABORT
);
  // ==========================================================
  // properties
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire take = CMD_VALID && CMD_READY;
  a_srq_mask_off: assert property (SRE_VALUE == 8'h00 |-> !SRQ)
    else $error("service request with zero mask");
  a_mss_sum: assert property (STATUS_BYTE[6] == |(STATUS_BYTE & SRE_VALUE & 8'hbf))
    else $error("summary bit 6 disagrees with masked status");
  a_sb_zero_bits: assert property (STATUS_BYTE[2:0] == 3'h0)
    else $error("status byte low bits not zero");
  a_mav_empty: assert property (OUTQ_EMPTY |-> !STATUS_BYTE[4])
    else $error("message available with empty queue");
  a_poll_copy: assert property ((POLL_BYTE & 8'hbf) == (STATUS_BYTE & 8'hbf))
    else $error("poll byte differs from status byte");
  a_poll_clear: assert property (SERIAL_POLL |=> !POLL_BYTE[6])
    else $error("request bit survived a poll");
  a_stb_answer: assert property (take && CMD_CODE == `ICS_CMD_STB_Q |=> RESP_VALID)
    else $error("status query not answered");
  a_wait_holds: assert property (take && CMD_CODE == `ICS_CMD_WAI && TRIG_BUSY |=> !CMD_READY)
    else $error("wait did not hold commands");
  a_recall_seq: assert property (take && CMD_CODE == `ICS_CMD_RCL |-> ##3 (STATE_LOAD && ABORT))
    else $error("recall did not load and abort");
  a_reset_abort: assert property (take && CMD_CODE == `ICS_CMD_RST |-> ##[1:3] ABORT)
    else $error("reset command did not abort");
  c_poll: cover property (SERIAL_POLL && POLL_BYTE[6]);
  c_recall: cover property (STATE_LOAD);
  c_wait: cover property (take && CMD_CODE == `ICS_CMD_WAI);
endmodule

// file: tb/ics_ctrl_model.sv
// bus controller model that hands commands to the unit
`timescale 1ns/10ps
`include "ics_defines.vh"
module ics_ctrl_model (
  // clock
  input wire       CLK,
  // command port
  output reg       CMD_VALID,
  input wire       CMD_READY,
  output reg [3:0] CMD_CODE,
  output reg [7:0] CMD_ARG,
  output reg       CMD_OVERLAP
);
  // ==========================================================
  // request driver
  initial begin
    CMD_VALID = 1'b0;
    CMD_CODE = `ICS_CMD_OTHER;
    CMD_ARG = 8'h00;
    CMD_OVERLAP = 1'b0;
  end
  // ready is looked at mid-cycle so the take edge is never raced
  task send(input [3:0] code, input [7:0] arg);
    integer n;
    begin
      n = 0;
      @(posedge CLK);
      #2;
      CMD_CODE = code;
      CMD_ARG = arg;
      CMD_VALID = 1'b1;
      @(negedge CLK);
      while (CMD_READY !== 1'b1 && n < 400) begin
        n = n + 1;
        @(negedge CLK);
      end
      @(posedge CLK);
      #2;
      CMD_VALID = 1'b0;
      // released lines carry junk, not the last request
      CMD_CODE = `ICS_CMD_OTHER;
      CMD_ARG = ~arg;
    end
  endtask
endmodule

// file: tb/ics_unit_bench.sv
// self-checking bench for the common-command and status unit
`timescale 1ns/10ps
`include "ics_defines.vh"
module ics_unit_bench;
  // ==========================================================
  // signals
  reg         CLK, RST_N, CMD_AFTER_TERM, OVL_BUSY, TRIG_BUSY, OPER_SUMMARY, QUES_SUMMARY;
  reg         EVT_CME, EVT_EXE, EVT_DDE, EVT_QUE, POWERON_RCL0, DEVICE_CLEAR, SERIAL_POLL;
  reg         SELFTEST_FAIL, OUTQ_EMPTY;
  reg  [7:0]  SELFTEST_CODE;
  reg  [31:0] STATE_IN;
  wire        CMD_VALID, CMD_READY, CMD_OVERLAP, RESP_VALID, ERRQ_PUSH, ERRQ_CLEAR, OUTQ_CLEAR;
  wire        EVREG_CLEAR, BUS_TRIGGER, ABORT, CAL_OFF, STATE_LOAD, OUTPUT_ON, SRQ, PSC_VALUE;
  wire [3:0]  CMD_CODE;
  wire [7:0]  CMD_ARG, RESP_DATA, ERRQ_CODE, STATUS_BYTE, POLL_BYTE, SRE_VALUE, ESE_VALUE;
  wire [31:0] STATE_OUT;
  wire [15:0] SWEEP_POINTS, SAMPLE_TICKS;
  wire [1:0]  TRIG_SOURCE;
  integer     num_errors, samples_checked, i, cyc;
  reg  [20:0] rows [0:8];
  reg  [6:0]  seen;
  reg         seen_clr;
  ics_unit DUT (.*);
  ics_ctrl_model CTL (.*);
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  // pulses are gathered so a late or early edge still counts
  always @(posedge CLK) begin
    seen <= seen_clr ? 7'h00 :
            (seen | {BUS_TRIGGER, ERRQ_PUSH, OUTQ_CLEAR, ERRQ_CLEAR, STATE_LOAD, ABORT, CAL_OFF});
    cyc = cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      give_verdict;
    end
  end
  // ==========================================================
  // tasks
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer k);
    begin
      repeat (k) @(posedge CLK);
      #2;
    end
  endtask
  task resp(input [7:0] exp);
    integer n;
    begin
      n = 0;
      @(negedge CLK);
      while (RESP_VALID !== 1'b1 && n < 200) begin
        n = n + 1;
        @(negedge CLK);
      end
      chk({24'h0, RESP_DATA}, {24'h0, exp});
    end
  endtask
  task clr_seen;
    begin
      seen_clr = 1'b1;
      tick(1);
      seen_clr = 1'b0;
    end
  endtask
  task give_verdict;
    begin
      $display("mismatches=%0d comparisons=%0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // ==========================================================
  // stimulus
  initial begin
    {RST_N, CMD_AFTER_TERM, OVL_BUSY, TRIG_BUSY, EVT_CME, EVT_EXE, EVT_DDE, EVT_QUE} = 8'h00;
    {POWERON_RCL0, DEVICE_CLEAR, SERIAL_POLL, SELFTEST_FAIL} = 4'h0;
    {OPER_SUMMARY, QUES_SUMMARY, OUTQ_EMPTY} = 3'h7;
    SELFTEST_CODE = 8'h2a;
    STATE_IN = 32'h0;
    seen_clr = 1'b1;
    // the nonvolatile store held power-on clear set before this power-up
    for (i = 0; i < 8; i = i + 1)
      DUT.u_nv.mem[i] = 32'h0001_0000;
    num_errors = 0;
    samples_checked = 0;
    cyc = 0;
    rows[0] = {1'b1, `ICS_CMD_ESR_Q, 8'h00, 8'h80};
    rows[1] = {1'b1, `ICS_CMD_ESR_Q, 8'h00, 8'h00};
    rows[2] = {1'b1, `ICS_CMD_OPT_Q, 8'h00, 8'h00};
    rows[3] = {1'b1, `ICS_CMD_TST_Q, 8'h00, 8'h00};
    rows[4] = {1'b1, `ICS_CMD_OPC_Q, 8'h00, 8'h31};
    rows[5] = {1'b0, `ICS_CMD_PSC, 8'h01, 8'h00};
    rows[6] = {1'b0, `ICS_CMD_ESE, 8'h10, 8'h00};
    rows[7] = {1'b0, `ICS_CMD_SRE, 8'h20, 8'h00};
    rows[8] = {1'b1, `ICS_CMD_STB_Q, 8'h00, 8'h88};
    tick(16);
    RST_N = 1'b1;
    seen_clr = 1'b0;
    tick(8);
    for (i = 0; i < 9; i = i + 1) begin
      CTL.send(rows[i][19:16], rows[i][15:8]);
      if (rows[i][20])
        resp(rows[i][7:0]);
    end
    {EVT_CME, EVT_EXE, EVT_DDE, EVT_QUE} = 4'hf;
    tick(1);
    {EVT_CME, EVT_EXE, EVT_DDE, EVT_QUE} = 4'h0;
    tick(2);
    chk(STATUS_BYTE, 8'he8);
    chk(SRQ, 1'b1);
    SERIAL_POLL = 1'b1;
    tick(1);
    SERIAL_POLL = 1'b0;
    tick(1);
    chk(POLL_BYTE, 8'ha8);
    CTL.send(`ICS_CMD_STB_Q, 8'h00);
    resp(8'he8);
    CTL.send(`ICS_CMD_ESR_Q, 8'h00);
    resp(8'h3c);
    tick(1);
    chk(STATUS_BYTE, 8'h88);
    CTL.send(`ICS_CMD_SRE, 8'h00);
    EVT_EXE = 1'b1;
    tick(1);
    EVT_EXE = 1'b0;
    tick(2);
    chk(SRQ, 1'b0);
    OVL_BUSY = 1'b1;
    CTL.send(`ICS_CMD_OPC, 8'h00);
    CTL.send(`ICS_CMD_ESR_Q, 8'h00);
    resp(8'h10);
    OVL_BUSY = 1'b0;
    tick(3);
    CTL.send(`ICS_CMD_ESR_Q, 8'h00);
    resp(8'h01);
    TRIG_BUSY = 1'b1;
    CTL.send(`ICS_CMD_OPC_Q, 8'h00);
    tick(6);
    chk(CMD_READY, 1'b0);
    TRIG_BUSY = 1'b0;
    resp(8'h31);
    TRIG_BUSY = 1'b1;
    CTL.send(`ICS_CMD_WAI, 8'h00);
    tick(6);
    chk(CMD_READY, 1'b0);
    DEVICE_CLEAR = 1'b1;
    tick(1);
    DEVICE_CLEAR = 1'b0;
    tick(2);
    chk(CMD_READY, 1'b1);
    TRIG_BUSY = 1'b0;
    STATE_IN = 32'h1234_5678;
    CTL.send(`ICS_CMD_SAV, 8'h02);
    tick(2);
    STATE_IN = 32'h0bad_0001;
    CTL.send(`ICS_CMD_SAV, 8'h01);
    tick(2);
    clr_seen;
    CTL.send(`ICS_CMD_RCL, 8'h02);
    tick(5);
    chk(STATE_OUT, 32'h1234_5678);
    chk(seen[2:0], 3'h7);
    SELFTEST_FAIL = 1'b1;
    clr_seen;
    CTL.send(`ICS_CMD_TST_Q, 8'h00);
    resp(8'h01);
    tick(1);
    chk(seen[5], 1'b1);
    chk(ERRQ_CODE, 8'h2a);
    CTL.send(`ICS_CMD_RST, 8'h00);
    tick(3);
    chk({SWEEP_POINTS, SAMPLE_TICKS}, 32'h0800_0138);
    chk({OUTPUT_ON, TRIG_SOURCE}, 3'h1);
    clr_seen;
    CTL.send(`ICS_CMD_TRG, 8'h00);
    tick(3);
    chk(seen[6], 1'b1);
    CMD_AFTER_TERM = 1'b1;
    clr_seen;
    CTL.send(`ICS_CMD_CLS, 8'h00);
    tick(3);
    chk(seen[4:3], 2'h3);
    // second power-up with clear off: enables must come back from storage
    CTL.send(`ICS_CMD_PSC, 8'h00);
    CTL.send(`ICS_CMD_SRE, 8'h20);
    tick(2);
    RST_N = 1'b0;
    tick(2);
    chk(SRE_VALUE, 8'h00);
    RST_N = 1'b1;
    tick(8);
    chk({PSC_VALUE, SRE_VALUE, ESE_VALUE}, 17'h0_2010);
    CTL.send(`ICS_CMD_ESR_Q, 8'h00);
    resp(8'h80);
    give_verdict;
  end
endmodule
bind ics_unit ics_unit_chk CHK (.*);
